/* logic/mb_slave_decoder.sv */
// serial slave request decoder: parses frames, issues writes and replies
//
// Operation
// - a frame is slave address, function code, fields, then a 2-byte CRC.
// - read requests carry a 16-bit start and a 16-bit quantity, MSB first.
// - code 0x03 is taken as a holding-register read with start and count.
// - code 0x06 carries a 16-bit register address and a 16-bit value.
// - code 0x05 carries a coil address and a value of 0x0000 or 0xFF00.
// - diagnostics 0x08 supports only subfunction 0x0000 plus a data word.
// - for subfunction 0x0000 the query data word is echoed unchanged.
// - code 0x07 has only address, function code and CRC.
// - code 0x0F carries start, quantity, byte count and packed coil bytes.
// - coil bit 0 of the first byte is the start coil, ascending onward.
// - code 0x10 carries start, quantity, count of twice that, then words.
// - broadcast frames are accepted only for 0x05, 0x06, 0x0F and 0x10.
// - no reply is ever sent for a broadcast frame.
// - an error reply carries the function code with its MSB set and a code.
// - a good reply echoes the function code and carries the own address.
// - the block answers individually only to its address within 1..247.
`timescale 1ns/1ps
`include "mb_slave_defs.svh"
module mb_slave_decoder (
    // clock and reset
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RST_B,
    // received frame bytes, CRC checked upstream
    input  wire logic        I_RX_VALID,
    input  wire logic [7:0]  I_RX_DATA,
    input  wire logic        I_RX_END,
    input  wire logic        I_RX_CRC_OK,
    // configuration and status
    input  wire logic [7:0]  I_SLAVE_ADDR,
    input  wire logic [7:0]  I_EXC_STATUS,
    // write port towards the application
    output logic             O_WR_VALID,
    output logic             O_WR_COIL,
    output logic [15:0]      O_WR_ADDR,
    output logic [15:0]      O_WR_DATA,
    output logic [7:0]       O_WR_MASK,
    // read request towards the application
    output logic             O_RD_VALID,
    output logic [7:0]       O_RD_FUNC,
    output logic [15:0]      O_RD_ADDR,
    output logic [15:0]      O_RD_QTY,
    // frame status
    output logic             O_FRAME_DONE,
    output logic             O_FRAME_OK,
    // reply stream, CRC appended downstream
    output logic             O_TX_VALID,
    output logic [7:0]       O_TX_DATA,
    output logic             O_TX_LAST,
    input  wire logic        I_TX_READY
);
    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------
    function automatic logic bcast_ok(input logic [7:0] fn);
        bcast_ok = (fn == `FN_WR_COIL) || (fn == `FN_WR_REG) ||
                   (fn == `FN_WR_COILS) || (fn == `FN_WR_REGS);
    endfunction : bcast_ok

    function automatic logic [8:0] exp_len(input logic [7:0] fn,
                                           input logic [7:0] cnt);
        case (fn)
            `FN_RD_COIL, `FN_RD_DIN, `FN_RD_HOLD, `FN_RD_INREG,
            `FN_WR_COIL, `FN_WR_REG, `FN_DIAG: exp_len = `LEN_FIXED;
            `FN_EXC_STAT:                      exp_len = `LEN_STAT;
            `FN_WR_COILS, `FN_WR_REGS:         exp_len = `IDX_DATA +
                                                         {1'b0, cnt};
            default:                           exp_len = `LEN_NONE;
        endcase
    endfunction : exp_len

    function automatic logic [7:0] exc_of(input logic [7:0]  fn,
                                          input logic [15:0] f1,
                                          input logic [15:0] f2,
                                          input logic [7:0]  cnt);
        case (fn)
            `FN_RD_COIL, `FN_RD_DIN, `FN_RD_HOLD, `FN_RD_INREG,
            `FN_WR_REG, `FN_EXC_STAT, `FN_WR_COILS, `FN_RW_REGS:
                exc_of = `EXC_NONE;
            `FN_WR_COIL: exc_of = (f2 == `COIL_OFF || f2 == `COIL_ON) ?
                                  `EXC_NONE : `EXC_ILL_VAL;
            `FN_DIAG:    exc_of = (f1 == `DIAG_ECHO) ?
                                  `EXC_NONE : `EXC_ILL_FN;
            `FN_WR_REGS: exc_of = ({9'h000, cnt} == {f2, 1'b0}) ?
                                  `EXC_NONE : `EXC_ILL_VAL;
            `FN_DEV_ID:  exc_of = (f1[15:8] == `DEV_ID_TYPE) ?
                                  `EXC_NONE : `EXC_ILL_FN;
            default:     exc_of = `EXC_ILL_FN;
        endcase
    endfunction : exc_of

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    mb_slave_pkg::rx_state_t st_ff, nxt_st;
    logic [8:0]  idx_ff, nxt_idx;
    logic [7:0]  addr_ff, nxt_addr;
    logic [7:0]  func_ff, nxt_func;
    logic [15:0] f1_ff, nxt_f1;
    logic [15:0] f2_ff, nxt_f2;
    logic [7:0]  cnt_ff, nxt_cnt;
    logic [7:0]  hi_ff, nxt_hi;
    logic        wr_valid_ff, nxt_wr_valid;
    logic        wr_coil_ff, nxt_wr_coil;
    logic [15:0] wr_addr_ff, nxt_wr_addr;
    logic [15:0] wr_data_ff, nxt_wr_data;
    logic [7:0]  wr_mask_ff, nxt_wr_mask;
    logic        rd_valid_ff, nxt_rd_valid;
    logic        done_ff, nxt_done;
    logic        ok_ff, nxt_ok;
    logic        rep_load;
    logic [47:0] rep_bytes;
    logic [2:0]  rep_len;
    logic        rep_busy;
    logic [7:0]  exc;
    logic [8:0]  pos;
    logic [15:0] coil_off;
    logic [15:0] coil_rem;
    logic        own_ok;
    logic        is_bcast;
    logic        good;
    logic [8:0]  want;

    // own address outside 1..247 means only broadcasts are heard
    assign own_ok   = (I_SLAVE_ADDR >= `ADDR_MIN) &&
                      (I_SLAVE_ADDR <= `ADDR_MAX);
    assign is_bcast = (addr_ff == `ADDR_BCAST);
    assign exc      = exc_of(func_ff, f1_ff, f2_ff, cnt_ff);
    assign pos      = idx_ff - `IDX_DATA;
    assign coil_off = {5'h00, pos[7:0], 3'h0};
    assign coil_rem = f2_ff - coil_off;
    assign want     = exp_len(func_ff, cnt_ff);
    assign good     = I_RX_CRC_OK && (st_ff == mb_slave_pkg::RX_TAKE) &&
                      (want == `LEN_NONE || idx_ff == want + `LEN_CRC);

    // ------------------------------------------------------------------
    // frame parser, write issue and reply selection
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st       = st_ff;
        nxt_idx      = idx_ff;
        nxt_addr     = addr_ff;
        nxt_func     = func_ff;
        nxt_f1       = f1_ff;
        nxt_f2       = f2_ff;
        nxt_cnt      = cnt_ff;
        nxt_hi       = hi_ff;
        nxt_wr_valid = 1'b0;
        nxt_wr_coil  = wr_coil_ff;
        nxt_wr_addr  = wr_addr_ff;
        nxt_wr_data  = wr_data_ff;
        nxt_wr_mask  = wr_mask_ff;
        nxt_rd_valid = 1'b0;
        nxt_done     = 1'b0;
        nxt_ok       = ok_ff;
        rep_load     = 1'b0;
        rep_len      = `REP_ECHO;
        rep_bytes    = {I_SLAVE_ADDR, func_ff, f1_ff, f2_ff};
        if (I_RX_END) begin
            nxt_st  = mb_slave_pkg::RX_IDLE;
            nxt_idx = 9'h000;
            if (st_ff != mb_slave_pkg::RX_IDLE) begin
                nxt_done = 1'b1;
                nxt_ok   = good && (exc == `EXC_NONE);
            end
            // single writes wait for the checked end of frame
            if (good && exc == `EXC_NONE) begin
                if (func_ff == `FN_WR_COIL) begin
                    nxt_wr_valid = 1'b1;
                    nxt_wr_coil  = 1'b1;
                    nxt_wr_addr  = f1_ff;
                    nxt_wr_data  = {15'h0000, f2_ff == `COIL_ON};
                    nxt_wr_mask  = `MASK_ONE;
                end else if (func_ff == `FN_WR_REG) begin
                    nxt_wr_valid = 1'b1;
                    nxt_wr_coil  = 1'b0;
                    nxt_wr_addr  = f1_ff;
                    nxt_wr_data  = f2_ff;
                    nxt_wr_mask  = `MASK_ALL;
                end
            end
            if (good && !is_bcast) begin
                if (exc != `EXC_NONE) begin
                    rep_load  = !rep_busy;
                    rep_len   = `REP_SHORT;
                    rep_bytes = {I_SLAVE_ADDR, func_ff | `EXC_FLAG,
                                 exc, 24'h000000};
                end else if (func_ff == `FN_EXC_STAT) begin
                    rep_load  = !rep_busy;
                    rep_len   = `REP_SHORT;
                    rep_bytes = {I_SLAVE_ADDR, func_ff, I_EXC_STATUS,
                                 24'h000000};
                end else if (func_ff == `FN_WR_COIL ||
                             func_ff == `FN_WR_REG ||
                             func_ff == `FN_DIAG ||
                             func_ff == `FN_WR_COILS ||
                             func_ff == `FN_WR_REGS) begin
                    rep_load  = !rep_busy;
                end else begin
                    nxt_rd_valid = 1'b1;
                end
            end
        end else if (I_RX_VALID) begin
            if (idx_ff != `IDX_SAT) begin
                nxt_idx = idx_ff + 9'h001;
            end
            case (st_ff)
                mb_slave_pkg::RX_IDLE: begin
                    nxt_idx  = `IDX_FUNC;
                    nxt_addr = I_RX_DATA;
                    nxt_f1   = 16'h0000;
                    nxt_f2   = 16'h0000;
                    nxt_cnt  = 8'h00;
                    nxt_st   = ((own_ok && I_RX_DATA == I_SLAVE_ADDR) ||
                                I_RX_DATA == `ADDR_BCAST) ?
                               mb_slave_pkg::RX_TAKE :
                               mb_slave_pkg::RX_SKIP;
                end
                mb_slave_pkg::RX_TAKE: begin
                    case (idx_ff)
                        `IDX_FUNC: begin
                            nxt_func = I_RX_DATA;
                            if (is_bcast && !bcast_ok(I_RX_DATA)) begin
                                nxt_st = mb_slave_pkg::RX_SKIP;
                            end
                        end
                        `IDX_F1_HI: nxt_f1[15:8] = I_RX_DATA;
                        `IDX_F1_LO: nxt_f1[7:0]  = I_RX_DATA;
                        `IDX_F2_HI: nxt_f2[15:8] = I_RX_DATA;
                        `IDX_F2_LO: nxt_f2[7:0]  = I_RX_DATA;
                        `IDX_CNT:   nxt_cnt      = I_RX_DATA;
                        default: begin
                            // multi writes go out as bytes arrive
                            if (pos < {1'b0, cnt_ff} &&
                                exc == `EXC_NONE) begin
                                if (func_ff == `FN_WR_COILS) begin
                                    nxt_wr_valid = 1'b1;
                                    nxt_wr_coil  = 1'b1;
                                    nxt_wr_addr  = f1_ff + coil_off;
                                    nxt_wr_data  = {8'h00, I_RX_DATA};
                                    nxt_wr_mask  =
                                        (coil_rem >= `COIL_STEP) ?
                                        `MASK_ALL :
                                        (`MASK_ONE << coil_rem[2:0]) -
                                        `MASK_ONE;
                                end else if (func_ff == `FN_WR_REGS) begin
                                    if (!pos[0]) begin
                                        nxt_hi = I_RX_DATA;
                                    end else begin
                                        nxt_wr_valid = 1'b1;
                                        nxt_wr_coil  = 1'b0;
                                        nxt_wr_addr  = f1_ff +
                                            {8'h00, pos[8:1]};
                                        nxt_wr_data  = {hi_ff,
                                                        I_RX_DATA};
                                        nxt_wr_mask  = `MASK_ALL;
                                    end
                                end
                            end
                        end
                    endcase
                end
                mb_slave_pkg::RX_SKIP: nxt_st = mb_slave_pkg::RX_SKIP;
                default:               nxt_st = mb_slave_pkg::RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            st_ff       <= mb_slave_pkg::RX_IDLE;
            idx_ff      <= 9'h000;
            addr_ff     <= 8'h00;
            func_ff     <= 8'h00;
            f1_ff       <= 16'h0000;
            f2_ff       <= 16'h0000;
            cnt_ff      <= 8'h00;
            hi_ff       <= 8'h00;
            wr_valid_ff <= 1'b0;
            wr_coil_ff  <= 1'b0;
            wr_addr_ff  <= 16'h0000;
            wr_data_ff  <= 16'h0000;
            wr_mask_ff  <= 8'h00;
            rd_valid_ff <= 1'b0;
            done_ff     <= 1'b0;
            ok_ff       <= 1'b0;
        end else begin
            st_ff       <= nxt_st;
            idx_ff      <= nxt_idx;
            addr_ff     <= nxt_addr;
            func_ff     <= nxt_func;
            f1_ff       <= nxt_f1;
            f2_ff       <= nxt_f2;
            cnt_ff      <= nxt_cnt;
            hi_ff       <= nxt_hi;
            wr_valid_ff <= nxt_wr_valid;
            wr_coil_ff  <= nxt_wr_coil;
            wr_addr_ff  <= nxt_wr_addr;
            wr_data_ff  <= nxt_wr_data;
            wr_mask_ff  <= nxt_wr_mask;
            rd_valid_ff <= nxt_rd_valid;
            done_ff     <= nxt_done;
            ok_ff       <= nxt_ok;
        end
    end

    // read requests carry the frame fields, which hold until the next frame
    assign O_WR_VALID   = wr_valid_ff;
    assign O_WR_COIL    = wr_coil_ff;
    assign O_WR_ADDR    = wr_addr_ff;
    assign O_WR_DATA    = wr_data_ff;
    assign O_WR_MASK    = wr_mask_ff;
    assign O_RD_VALID   = rd_valid_ff;
    assign O_RD_FUNC    = func_ff;
    assign O_RD_ADDR    = f1_ff;
    assign O_RD_QTY     = f2_ff;
    assign O_FRAME_DONE = done_ff;
    assign O_FRAME_OK   = ok_ff;

    // ------------------------------------------------------------------
    // reply serializer
    // ------------------------------------------------------------------
    mb_reply_tx u_reply (
        .i_clk      (I_CORE_CLK),
        .i_rst_b    (I_RST_B),
        .i_load     (rep_load),
        .i_bytes    (rep_bytes),
        .i_len      (rep_len),
        .o_busy     (rep_busy),
        .o_tx_valid (O_TX_VALID),
        .o_tx_data  (O_TX_DATA),
        .o_tx_last  (O_TX_LAST),
        .i_tx_ready (I_TX_READY)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_B);

    sequence s_load;
        rep_load && !rep_busy;
    endsequence
    sequence s_first_byte;
        O_TX_VALID && O_TX_DATA == I_SLAVE_ADDR;
    endsequence

    no_bcast_reply_a: assert property (is_bcast |-> !rep_load)
        else $error("reply loaded for a broadcast frame");
    reply_own_addr_a: assert property (s_load |=> s_first_byte)
        else $error("reply does not start with own address");
    addr_range_a: assert property (rep_load |-> own_ok)
        else $error("reply sent with own address out of range");
    exc_code_a: assert property (rep_load && exc != `EXC_NONE |->
        rep_len == `REP_SHORT && rep_bytes[39:32] == (func_ff | `EXC_FLAG))
        else $error("exception reply lacks flagged function code");
    diag_echo_a: assert property (rep_load && func_ff == `FN_DIAG &&
        exc == `EXC_NONE |-> f1_ff == `DIAG_ECHO &&
        rep_bytes[15:0] == f2_ff)
        else $error("diagnostic data not echoed");
    unknown_fn_a: assert property (I_RX_END && good &&
        exp_len(func_ff, cnt_ff) == `LEN_NONE &&
        func_ff != `FN_RW_REGS && func_ff != `FN_DEV_ID && !is_bcast
        |-> ##1 !O_RD_VALID && !O_FRAME_OK)
        else $error("unknown function code not refused");
    bcast_write_a: assert property (O_WR_VALID && is_bcast |->
        bcast_ok(func_ff))
        else $error("broadcast write for a refused function");
    coil_value_a: assert property (O_WR_VALID && func_ff == `FN_WR_COIL
        |-> O_WR_MASK == `MASK_ONE &&
        O_WR_DATA[0] == (f2_ff == `COIL_ON))
        else $error("single coil write value wrong");
    reg_pair_a: assert property (O_WR_VALID && func_ff == `FN_WR_REGS
        |-> !O_WR_COIL && O_WR_MASK == `MASK_ALL)
        else $error("register write malformed");
endmodule : mb_slave_decoder

/* logic/mb_slave_defs.svh */
// constants for the serial request decoder: codes, lengths, field indices
`ifndef MB_SLAVE_DEFS_SVH
`define MB_SLAVE_DEFS_SVH

// ----------------------------------------------------------------------
// function codes
// ----------------------------------------------------------------------
`define FN_RD_COIL    8'h01
`define FN_RD_DIN     8'h02
`define FN_RD_HOLD    8'h03
`define FN_RD_INREG   8'h04
`define FN_WR_COIL    8'h05
`define FN_WR_REG     8'h06
`define FN_EXC_STAT   8'h07
`define FN_DIAG       8'h08
`define FN_WR_COILS   8'h0F
`define FN_WR_REGS    8'h10
`define FN_RW_REGS    8'h17
`define FN_DEV_ID     8'h2B
`define DEV_ID_TYPE   8'h0E
`define DIAG_ECHO     16'h0000

// ----------------------------------------------------------------------
// values, exception codes and addresses
// ----------------------------------------------------------------------
`define COIL_OFF      16'h0000
`define COIL_ON       16'hFF00
`define EXC_FLAG      8'h80
`define EXC_NONE      8'h00
`define EXC_ILL_FN    8'h01
`define EXC_ILL_VAL   8'h03
`define ADDR_BCAST    8'h00
`define ADDR_MIN      8'h01
`define ADDR_MAX      8'hF7
`define MASK_ALL      8'hFF
`define MASK_ONE      8'h01
`define COIL_STEP     16'h0008

// ----------------------------------------------------------------------
// byte positions within a frame and frame lengths
// ----------------------------------------------------------------------
`define IDX_FUNC      9'h001
`define IDX_F1_HI     9'h002
`define IDX_F1_LO     9'h003
`define IDX_F2_HI     9'h004
`define IDX_F2_LO     9'h005
`define IDX_CNT       9'h006
`define IDX_DATA      9'h007
`define IDX_SAT       9'h1FF
`define LEN_FIXED     9'h006
`define LEN_STAT      9'h002
`define LEN_CRC       9'h002
`define LEN_NONE      9'h000
`define REP_ECHO      3'h6
`define REP_SHORT     3'h3

`endif

/* logic/mb_slave_pkg.sv */
// types shared by the request decoder
package mb_slave_pkg;
    typedef enum logic [1:0] {RX_IDLE, RX_TAKE, RX_SKIP} rx_state_t;
endpackage : mb_slave_pkg

/* logic/mb_reply_tx.sv */
// reply byte serializer: sends up to six loaded bytes, first byte first
`timescale 1ns/1ps
`include "mb_slave_defs.svh"
module mb_reply_tx (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // load side
    input  wire logic        i_load,
    input  wire logic [47:0] i_bytes,
    input  wire logic [2:0]  i_len,
    output logic             o_busy,
    // byte stream
    output logic             o_tx_valid,
    output logic [7:0]       o_tx_data,
    output logic             o_tx_last,
    input  wire logic        i_tx_ready
);
    logic [47:0] buf_ff;
    logic [47:0] nxt_buf;
    logic [2:0]  left_ff;
    logic [2:0]  nxt_left;

    // ------------------------------------------------------------------
    // shift register; a load is only taken while idle
    // ------------------------------------------------------------------
    always_comb begin
        nxt_buf  = buf_ff;
        nxt_left = left_ff;
        if (left_ff == 3'h0) begin
            if (i_load) begin
                nxt_buf  = i_bytes;
                nxt_left = i_len;
            end
        end else if (i_tx_ready) begin
            nxt_buf  = {buf_ff[39:0], 8'h00};
            nxt_left = left_ff - 3'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            buf_ff  <= 48'h000000000000;
            left_ff <= 3'h0;
        end else begin
            buf_ff  <= nxt_buf;
            left_ff <= nxt_left;
        end
    end

    // handshake outputs may be combinational, data comes from the flops
    assign o_busy     = (left_ff != 3'h0);
    assign o_tx_valid = (left_ff != 3'h0);
    assign o_tx_last  = (left_ff == 3'h1);
    assign o_tx_data  = buf_ff[47:40];
endmodule : mb_reply_tx

/* verification/mb_master_model.sv */
// bus master model: sends request frames and takes reply bytes
`timescale 1ns/1ps
module mb_master_model (
    // clock
    input  wire logic       i_clk,
    // request byte stream
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_data,
    output logic            o_rx_end,
    output logic            o_crc_ok,
    // reply sink
    output logic            o_tx_ready
);
    integer rdy_seed = 28;
    initial begin
        o_rx_valid = 1'b0;
        o_rx_data  = 8'h00;
        o_rx_end   = 1'b0;
        o_crc_ok   = 1'b0;
        o_tx_ready = 1'b0;
    end
    // sink stalls at random, so replies are taken both fast and slow
    always @(negedge i_clk) o_tx_ready <= |($random(rdy_seed) & 32'h3);
    // n frame bytes, address first, then two check bytes and the end mark
    task automatic send(input logic [95:0] f, input int n, input logic ok);
        for (int i = 0; i < n + 2; i++) begin
            @(negedge i_clk);
            o_rx_valid = 1'b1;
            o_rx_data  = (i < n) ? f[8*(n-1-i) +: 8] : 8'h5A;
        end
        @(negedge i_clk);
        o_rx_valid = 1'b0;
        o_rx_data  = ~o_rx_data; // idle line never shows a stale byte
        o_rx_end   = 1'b1;
        o_crc_ok   = ok;
        @(negedge i_clk);
        o_rx_end   = 1'b0;
        o_crc_ok   = ~ok;
    endtask : send
endmodule : mb_master_model

/* verification/tb_mb_slave_decoder.sv */
// self-checking bench for the serial request decoder
`timescale 1ns/1ps
module tb_mb_slave_decoder;
    logic        core_clk = 1'b0;
    logic        rst_b    = 1'b0;
    logic        rx_valid, rx_end, crc_ok, tx_ready, done, ok;
    logic        wr_valid, wr_coil, rd_valid, tx_valid, tx_last;
    logic [7:0]  rx_data, rd_func, tx_data, wr_mask;
    logic [7:0]  own = 8'h12;
    logic [7:0]  exc = 8'h00;
    logic [15:0] wr_addr, wr_data, rd_addr, rd_qty, d;
    logic [47:0] tq[$], wq[$], rq[$], fq[$];
    integer      seed = 28;
    int          error_cnt, n_compared, cyc;
    always #2.5 core_clk = ~core_clk;
    mb_master_model mb_master_model_inst (.i_clk(core_clk),
        .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_end(rx_end),
        .o_crc_ok(crc_ok), .o_tx_ready(tx_ready));
    mb_slave_decoder mb_slave_decoder_inst (.I_CORE_CLK(core_clk),
        .I_RST_B(rst_b), .I_RX_VALID(rx_valid), .I_RX_DATA(rx_data),
        .I_RX_END(rx_end), .I_RX_CRC_OK(crc_ok), .I_SLAVE_ADDR(own),
        .I_EXC_STATUS(exc), .O_WR_VALID(wr_valid), .O_WR_COIL(wr_coil),
        .O_WR_ADDR(wr_addr), .O_WR_DATA(wr_data), .O_WR_MASK(wr_mask),
        .O_RD_VALID(rd_valid), .O_RD_FUNC(rd_func), .O_RD_ADDR(rd_addr),
        .O_RD_QTY(rd_qty), .O_FRAME_DONE(done), .O_FRAME_OK(ok),
        .O_TX_VALID(tx_valid), .O_TX_DATA(tx_data), .O_TX_LAST(tx_last),
        .I_TX_READY(tx_ready));
    // each result takes the oldest note of its kind; none noted means X
    always @(posedge core_clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
            cmp("reply", tq.size() ? tq.pop_front() : 48'hX,
                48'({tx_last, tx_data}));
        if (wr_valid === 1'b1)
            cmp("write", wq.size() ? wq.pop_front() : 48'hX,
                48'({wr_coil, wr_addr, wr_data, wr_mask}));
        if (rd_valid === 1'b1)
            cmp("read", rq.size() ? rq.pop_front() : 48'hX,
                48'({rd_func, rd_addr, rd_qty}));
        if (done === 1'b1)
            cmp("frame", fq.size() ? fq.pop_front() : 48'hX, 48'(ok));
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic cmp(input string nm, input logic [47:0] e, g);
        n_compared++;
        if (e !== g) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    // note n reply bytes, first byte first, the final one flagged last
    task automatic ex(input logic [47:0] r, input int n);
        for (int i = n - 1; i >= 0; i--)
            tq.push_back(48'({i == 0, r[8*i +: 8]}));
    endtask : ex
    // send one frame, then wait a bounded time for every note to be met
    // every frame ends in one done pulse; want_ok low for refused frames
    task automatic run(input logic [95:0] f, input int n, input logic g,
                       input logic want_ok = 1'b1);
        fq.push_back(48'(g & want_ok));
        mb_master_model_inst.send(f, n, g);
        for (int k = 0; k < 80 && (tq.size() + wq.size() + rq.size() +
             fq.size() > 0 || tx_valid !== 1'b0); k++)
            @(negedge core_clk);
        repeat (4) @(negedge core_clk);
        cmp("pending", 48'h0, 48'(tq.size() + wq.size() + rq.size() +
            fq.size()));
    endtask : run
    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        own = 8'h01 + 8'($unsigned($random(seed)) % 247);
        exc = 8'($random(seed));
        repeat (3) @(negedge core_clk);
        rst_b = 1'b1;
        for (int k = 0; k < 3; k++) begin
            d = 16'($random(seed));
            wq.push_back({1'b0, 16'h07D0, d, 8'hFF});
            ex({own, 24'h0607D0, d}, 6);
            run({own, 24'h0607D0, d}, 6, 1'b1);
        end
        ex({own, 16'h8503}, 3);
        run({own, 40'h0507D01234}, 6, 1'b1, 1'b0);
        wq.push_back({1'b1, 16'h07D0, 16'h0001, 8'h01});
        ex({own, 40'h0507D0FF00}, 6);
        run({own, 40'h0507D0FF00}, 6, 1'b1);
        wq.push_back({1'b1, 16'h0013, 16'h00CD, 8'hFF});
        wq.push_back({1'b1, 16'h001B, 16'h0001, 8'h03});
        ex({own, 40'h0F0013000A}, 6);
        run({own, 64'h0F0013000A02CD01}, 9, 1'b1);
        wq.push_back({1'b0, 16'h07D0, 16'h0001, 8'hFF});
        wq.push_back({1'b0, 16'h07D1, 16'h0002, 8'hFF});
        ex({own, 40'h1007D00002}, 6);
        run({own, 80'h1007D000020400010002}, 11, 1'b1);
        for (int f = 1; f < 5; f++) begin
            rq.push_back({8'(f), 32'h07D00003});
            run({own, 8'(f), 32'h07D00003}, 6, 1'b1);
        end
        ex({own, 8'h07, exc}, 3);
        run({own, 8'h07}, 2, 1'b1);
        ex({own, 40'h080000A5A5}, 6);
        run({own, 40'h080000A5A5}, 6, 1'b1);
        ex({own, 16'h8801}, 3);
        run({own, 40'h080001A5A5}, 6, 1'b1, 1'b0);
        wq.push_back({1'b0, 16'h0010, 16'hBEEF, 8'hFF});
        run({8'h00, 40'h060010BEEF}, 6, 1'b1);
        run({8'h00, 40'h0307D00003}, 6, 1'b1, 1'b0);
        run({~own, 40'h0607D00005}, 6, 1'b1, 1'b0);
        ex({own, 16'hC101}, 3);
        run({own, 40'h4100000000}, 6, 1'b1, 1'b0);
        rq.push_back({8'h17, 32'h07D00002});
        run({own, 40'h1707D00002}, 6, 1'b1);
        rq.push_back({8'h2B, 32'h0E010000});
        run({own, 40'h2B0E010000}, 6, 1'b1);
        ex({own, 16'hAB01}, 3);
        run({own, 40'h2B05010000}, 6, 1'b1, 1'b0);
        run({own, 40'h0607D00005}, 6, 1'b0);
        close_out();
    end
endmodule : tb_mb_slave_decoder
